// ==== rtl/anps_pkg.sv ====
// Constants for the auto-negotiation partner page status registers
package anps_pkg;
  localparam int          REG_W            = 16;
  localparam int          ADDR_W           = 8;
  localparam logic [7:0]  OFF_PARTNER_ABIL = 8'h5a;
  localparam logic [7:0]  OFF_PAGE_EXP     = 8'h5c;
  localparam logic [15:0] RST_PARTNER_ABIL = 16'h0000;
  localparam logic [15:0] RST_PAGE_EXP     = 16'h0004;
  // Bits of the partner ability word that are kept; rest read zero
  localparam logic [15:0] ABIL_KEEP_MASK   = 16'hf1e0;
  localparam int          BIT_NEXT_PAGE    = 15;
  localparam int          BIT_ACK          = 14;
  localparam int          BIT_FAULT_HI     = 13;
  localparam int          BIT_FAULT_LO     = 12;
  localparam int          BIT_ASYM_PAUSE   = 8;
  localparam int          BIT_PAUSE        = 7;
  localparam int          BIT_HALF_DUPLEX  = 6;
  localparam int          BIT_FULL_DUPLEX  = 5;
  localparam int          BIT_NP_RECEIVED  = 7;
  localparam int          BIT_NP_ABLE      = 2;
  localparam int          BIT_PAGE_RCVD    = 1;
endpackage

// ==== rtl/anps_rd_mux.sv ====
// Read data selection for the two status registers
`timescale 1ns/1ps
`default_nettype none
module anps_rd_mux (
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] abil,
  input  wire logic [15:0] expn,
  output logic      [15:0] rdata,
  output logic             hit_exp
);
  always_comb begin
    hit_exp = (addr == anps_pkg::OFF_PAGE_EXP);
    if (addr == anps_pkg::OFF_PARTNER_ABIL) begin
      rdata = abil;
    end else if (hit_exp) begin
      rdata = expn;
    end else begin
      rdata = 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/anps_status.sv ====
// Auto-negotiation partner base page and page expansion status registers
`timescale 1ns/1ps
`default_nettype none
module anps_status (
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Page exchange side
  input  wire logic        page_exchange_done,
  input  wire logic [15:0] base_page_word,
  input  wire logic        page_rcvd_pulse,
  input  wire logic        page_is_next,
  // CPU register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata
);
  logic [15:0] partner_base_page_ability;
  logic        next_page_received;
  logic        page_received_flag;
  logic [15:0] autoneg_page_expansion;
  logic        hit_exp;
  logic [15:0] next_rdata;
  logic        rd_exp;

  // Shared by the capture and its check so the mask lives in one place
  function automatic logic [15:0] capture_abil(input logic [15:0] w);
    return w & anps_pkg::ABIL_KEEP_MASK;
  endfunction

  // Writes are decoded nowhere: both registers ignore them
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      partner_base_page_ability <= anps_pkg::RST_PARTNER_ABIL;
    end else if (page_exchange_done) begin
      // Bits 15,14,13:12,8,7,6,5 straight from the page
      partner_base_page_ability <= capture_abil(base_page_word);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      next_page_received <= 1'b0;
    end else if (page_rcvd_pulse) begin
      next_page_received <= page_is_next;
    end
  end

  assign rd_exp = reg_rd && hit_exp;

  // New page wins over a clearing read in the same cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      page_received_flag <= 1'b0;
    end else if (page_rcvd_pulse) begin
      page_received_flag <= 1'b1;
    end else if (rd_exp) begin
      page_received_flag <= 1'b0;
    end
  end

  always_comb begin
    autoneg_page_expansion = 16'h0000;
    autoneg_page_expansion[anps_pkg::BIT_NP_RECEIVED] = next_page_received;
    autoneg_page_expansion[anps_pkg::BIT_NP_ABLE] = 1'b1;
    autoneg_page_expansion[anps_pkg::BIT_PAGE_RCVD] = page_received_flag;
  end

  anps_rd_mux u_mux (
    .addr    (reg_addr),
    .abil    (partner_base_page_ability),
    .expn    (autoneg_page_expansion),
    .rdata   (next_rdata),
    .hit_exp (hit_exp)
  );

  // Registered read data, one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  a_abil_holds: assert property (@(posedge mclk) disable iff (!nrst)
    !page_exchange_done |=> $stable(partner_base_page_ability))
    else $error("ability changed without page exchange end");

  a_abil_loads: assert property (@(posedge mclk) disable iff (!nrst)
    page_exchange_done |=> partner_base_page_ability ==
      capture_abil($past(base_page_word)))
    else $error("ability word not captured");

  a_abil_resv_zero: assert property (@(posedge mclk) disable iff (!nrst)
    (partner_base_page_ability & ~anps_pkg::ABIL_KEEP_MASK) == 16'h0000)
    else $error("ability reserved bit set");

  a_flag_sets: assert property (@(posedge mclk) disable iff (!nrst)
    page_rcvd_pulse |=> page_received_flag)
    else $error("page received flag not set");

  sequence s_clear_read;
    rd_exp && !page_rcvd_pulse;
  endsequence
  a_flag_clears: assert property (@(posedge mclk) disable iff (!nrst)
    s_clear_read |=> !page_received_flag)
    else $error("flag not cleared by read");

  a_flag_read_val: assert property (@(posedge mclk) disable iff (!nrst)
    rd_exp |=> reg_rdata[anps_pkg::BIT_PAGE_RCVD] == $past(page_received_flag))
    else $error("read lost flag value");

  a_np_able_fixed: assert property (@(posedge mclk) disable iff (!nrst)
    rd_exp |=> reg_rdata[anps_pkg::BIT_NP_ABLE] && reg_rdata[15:8] == 8'h00)
    else $error("expansion fixed bits wrong");

  a_np_kind: assert property (@(posedge mclk) disable iff (!nrst)
    page_rcvd_pulse |=> next_page_received == $past(page_is_next))
    else $error("next page kind wrong");

  a_next_req_bit: assert property (@(posedge mclk) disable iff (!nrst)
    page_exchange_done |=> partner_base_page_ability[anps_pkg::BIT_NEXT_PAGE] ==
      $past(base_page_word[anps_pkg::BIT_NEXT_PAGE]))
    else $error("next page request bit wrong");

  a_ack_bit: assert property (@(posedge mclk) disable iff (!nrst)
    page_exchange_done |=> partner_base_page_ability[anps_pkg::BIT_ACK] ==
      $past(base_page_word[anps_pkg::BIT_ACK]))
    else $error("acknowledge bit wrong");

  a_fault_code: assert property (@(posedge mclk) disable iff (!nrst)
    page_exchange_done |=>
      partner_base_page_ability[anps_pkg::BIT_FAULT_HI:anps_pkg::BIT_FAULT_LO] ==
      $past(base_page_word[anps_pkg::BIT_FAULT_HI:anps_pkg::BIT_FAULT_LO]))
    else $error("fault code wrong");

  a_asym_pause: assert property (@(posedge mclk) disable iff (!nrst)
    page_exchange_done |=> partner_base_page_ability[anps_pkg::BIT_ASYM_PAUSE] ==
      $past(base_page_word[anps_pkg::BIT_ASYM_PAUSE]))
    else $error("asymmetric pause bit wrong");

  a_pause_bit: assert property (@(posedge mclk) disable iff (!nrst)
    page_exchange_done |=> partner_base_page_ability[anps_pkg::BIT_PAUSE] ==
      $past(base_page_word[anps_pkg::BIT_PAUSE]))
    else $error("pause bit wrong");

  a_duplex_bits: assert property (@(posedge mclk) disable iff (!nrst)
    page_exchange_done |=>
      partner_base_page_ability[anps_pkg::BIT_HALF_DUPLEX] ==
        $past(base_page_word[anps_pkg::BIT_HALF_DUPLEX]) &&
      partner_base_page_ability[anps_pkg::BIT_FULL_DUPLEX] ==
        $past(base_page_word[anps_pkg::BIT_FULL_DUPLEX]))
    else $error("duplex bits wrong");

  // Any write of nonzero data, outside a page exchange end, must leave the captured word alone
  sequence s_plain_write;
    reg_wr && (reg_wdata != 16'h0000) && !page_exchange_done;
  endsequence
  a_write_ignored: assert property (@(posedge mclk) disable iff (!nrst)
    s_plain_write |=> $stable(partner_base_page_ability))
    else $error("write changed ability word");

  a_exp_resv_zero: assert property (@(posedge mclk) disable iff (!nrst)
    autoneg_page_expansion[15:8] == 8'h00 && autoneg_page_expansion[6:3] == 4'h0 &&
      !autoneg_page_expansion[0])
    else $error("expansion reserved bit set");

  a_np_able_const: assert property (@(posedge mclk) disable iff (!nrst)
    autoneg_page_expansion[anps_pkg::BIT_NP_ABLE])
    else $error("next page able bit low");

  sequence s_read_abil;
    reg_rd && (reg_addr == anps_pkg::OFF_PARTNER_ABIL);
  endsequence
  a_rdata_abil: assert property (@(posedge mclk) disable iff (!nrst)
    s_read_abil |=> reg_rdata == $past(partner_base_page_ability))
    else $error("ability read data wrong");

  a_rdata_exp: assert property (@(posedge mclk) disable iff (!nrst)
    rd_exp |=> reg_rdata == $past(autoneg_page_expansion))
    else $error("expansion read data wrong");

  sequence s_read_unmapped;
    reg_rd && (reg_addr != anps_pkg::OFF_PARTNER_ABIL) && !hit_exp;
  endsequence
  a_rdata_unmapped: assert property (@(posedge mclk) disable iff (!nrst)
    s_read_unmapped |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");

  a_rdata_holds: assert property (@(posedge mclk) disable iff (!nrst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  // Read and new page in one cycle: the read sees the old flag, the page wins
  sequence s_set_during_read;
    rd_exp && page_rcvd_pulse;
  endsequence
  a_flag_set_wins: assert property (@(posedge mclk) disable iff (!nrst)
    s_set_during_read |=> page_received_flag)
    else $error("clearing read beat new page");

  a_np_holds: assert property (@(posedge mclk) disable iff (!nrst)
    !page_rcvd_pulse |=> $stable(next_page_received))
    else $error("page kind moved without a page");

  a_flag_holds: assert property (@(posedge mclk) disable iff (!nrst)
    !page_rcvd_pulse && !rd_exp |=> $stable(page_received_flag))
    else $error("flag moved without cause");

  a_reset_abil: assert property (@(posedge mclk)
    !nrst |=> partner_base_page_ability == anps_pkg::RST_PARTNER_ABIL)
    else $error("ability not reset");

  a_reset_exp: assert property (@(posedge mclk)
    !nrst |=> autoneg_page_expansion == anps_pkg::RST_PAGE_EXP)
    else $error("expansion not reset");

  a_reset_rdata: assert property (@(posedge mclk)
    !nrst |=> reg_rdata == 16'h0000)
    else $error("read data not reset");
endmodule
`default_nettype wire

// ==== tb/anps_peer.sv ====
// Link partner model delivering received pages
`timescale 1ns/1ps
`default_nettype none
module anps_peer (
  input  wire logic        mclk,
  output logic             done,
  output logic      [15:0] word,
  output logic             rcvd,
  output logic             is_next
);
  initial begin
    done = 1'b0;
    word = 16'h0000;
    rcvd = 1'b0;
    is_next = 1'b0;
  end
  task automatic base_page(input logic [15:0] w);
    @(posedge mclk);
    done <= 1'b1;
    word <= w;
    @(posedge mclk);
    done <= 1'b0;
    word <= ~w; // Stale word must never be reloaded
  endtask
  task automatic page(input logic nxt);
    @(posedge mclk);
    rcvd <= 1'b1;
    is_next <= nxt;
    @(posedge mclk);
    rcvd <= 1'b0;
    is_next <= ~nxt;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the partner page status registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_rd = 1'b0;
  logic        reg_wr = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, word, v;
  logic        done, rcvd, is_next;
  int          err_total = 0;
  int          n_checks = 0;
  always #2.5 mclk = ~mclk;
  anps_peer peer (.mclk(mclk), .done(done), .word(word), .rcvd(rcvd), .is_next(is_next));
  anps_status dut (.mclk(mclk), .nrst(nrst), .page_exchange_done(done),
    .base_page_word(word), .page_rcvd_pulse(rcvd), .page_is_next(is_next),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic wr(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= 16'hffff;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic t_reset;
    rd(8'h5a); check("ability", v, 16'h0000);
    rd(8'h5c); check("expansion", v, 16'h0004);
    rd(8'h10); check("unmapped", v, 16'h0000);
  endtask
  task automatic t_load;
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      // Every fault code, with reserved bits set on odd runs
      w = {i[0], i[1], i[1:0], i[0] ? 12'hfff : 12'h0a0};
      peer.base_page(w);
      rd(8'h5a); check("ability", v, {w[15:12], 3'b000, w[8:5], 5'b0});
    end
    wr(8'h5a);
    peer.page(1'b0);
    rd(8'h5a); check("ability held", v, {w[15:12], 3'b000, w[8:5], 5'b0});
  endtask
  task automatic t_page;
    rd(8'h5c);
    peer.page(1'b1);
    rd(8'h5c); check("next page", v, 16'h0086);
    rd(8'h5c); check("cleared", v, 16'h0084);
    peer.page(1'b0);
    wr(8'h5c);
    rd(8'h5c); check("base page", v, 16'h0006);
    fork
      rd(8'h5c);
      peer.page(1'b1);
    join
    check("read vs page", v, 16'h0004);
    rd(8'h5c); check("set wins", v, 16'h0086);
  endtask
  task automatic t_rerun;
    peer.page(1'b1);
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rd(8'h5a); check("ability rerun", v, 16'h0000);
    rd(8'h5c); check("expansion rerun", v, 16'h0004);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_load();
    t_page();
    t_rerun();
    conclude();
  end
  // Whole run is about 60 cycles, well under the 1000-cycle limit
  initial begin
    #5000;
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
